// ==== tlb_test_pkg.sv ====
// Constants, field layouts and state type for the TLB test access block
package tlb_test_pkg;

  // Field positions in the control word
  localparam int LIN_LO = 12;
  localparam int VALID_BIT = 11;
  localparam int ATTR_LO = 5;
  localparam int CMD_BIT = 0;

  // Field positions in the data word
  localparam int PHYS_LO = 12;
  localparam int LRU_LO = 7;
  localparam int HIT_BIT = 4;
  localparam int WAYSEL_LO = 2;

  // Field widths
  localparam int PAGE_W = 20;
  localparam int ATTR_PAIRS = 3;
  localparam int ATTR_W = 2 * ATTR_PAIRS;
  localparam int LRU_W = 3;
  localparam int WAYS = 4;
  localparam int WAY_W = 2;
  localparam int ENTRY_W = PAGE_W + ATTR_PAIRS + PAGE_W;

  // Reserved gaps, read as zero
  localparam int CTL_GAP_W = 4;
  localparam int DAT_GAP_HI_W = 2;
  localparam int DAT_GAP_MID_W = 2;
  localparam int DAT_GAP_LO_W = 2;

  // Pseudo-LRU bit positions within a set's three bits
  localparam int PLRU_HALF = 0;
  localparam int PLRU_LOW_PAIR = 1;
  localparam int PLRU_HIGH_PAIR = 2;

  // Encodings
  localparam logic CMD_LOOKUP = 1'b1;
  localparam logic REG_SEL_CONTROL = 1'b0;
  localparam logic REG_SEL_DATA = 1'b1;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [LRU_W-1:0] LRU_RESET = 3'h0;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_LOOKUP,
    OP_WRITE
  } op_state_t;

endpackage : tlb_test_pkg

// ==== tlb_entry_store.sv ====
// Entry storage of the TLB: one write port, all ways of a set read at once
`timescale 1ns/1ps
module tlb_entry_store #(
  parameter int SETS = 8,
  parameter int WAYS = 4,
  parameter int WIDTH = 43
) (
  input wire logic clk_sys,
  input wire logic rd_en,
  input wire logic [$clog2(SETS)-1:0] rd_set,
  input wire logic wr_en,
  input wire logic [$clog2(SETS)-1:0] wr_set,
  input wire logic [$clog2(WAYS)-1:0] wr_way,
  input wire logic [WIDTH-1:0] wr_entry,
  output logic [WAYS*WIDTH-1:0] rd_ways
);

  logic [WIDTH-1:0] mem [SETS*WAYS];

  wire [$clog2(SETS*WAYS)-1:0] wr_index = {wr_set, wr_way};

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_index] <= wr_entry;
    end
  end

  // Read data held in a register, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      for (int w = 0; w < WAYS; w++) begin
        rd_ways[w*WIDTH +: WIDTH] <= mem[{rd_set, w[$clog2(WAYS)-1:0]}];
      end
    end
  end

endmodule : tlb_entry_store

// ==== tlb_test_access.sv ====
// TLB with its two privileged test registers for lookup and entry write
`timescale 1ns/1ps

// How it works
// - Lookup returns matching page in data word; write stores that field into entry.
// - Lookup reports the set's replacement bits from before; write ignores them.
// - Hit flag is 1 after a lookup hit, 0 after a miss.
// - Write picks way from set field if hit flag set, else pseudo-LRU victim.
// - After a hit the set field names the way found; miss leaves it.
// - Set field selects the way on a write only when hit flag is set.
// - Lookup searches with the linear page held in the control word.
// - A lookup hit refreshes valid and attribute fields from the entry.
// - A write allocates an entry to the control word's linear page.
// - Write marks the entry valid when valid bit is 1, invalid otherwise.
// - Control word holds dirty, user and write attribute pairs with complements.
// - Lookup pair: 00 never, 01 stored zero, 10 stored one, 11 any.
// - Write pair: 01 clears, 10 sets; 00 and 11 store the upper bit.
// - Command bit chooses lookup or entry write.
// - Thirty-two entries in four ways, 23-bit tag and 20-bit page each.
// - Tag is whole linear page and three attribute bits; valid bit kept beside it.
// - Test registers answer only at privilege level zero.
module tlb_test_access #(
  parameter int ENTRIES = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic test_reg_write,
  input wire logic test_reg_read,
  input wire logic test_reg_sel,
  input wire logic [31:0] test_reg_wdata,
  input wire logic [1:0] privilege_level,
  output logic [31:0] test_reg_rdata,
  output logic access_denied,
  output logic busy
);

  localparam int SETS = ENTRIES / tlb_test_pkg::WAYS;
  localparam int IDX_W = $clog2(SETS);
  localparam int PAGE_W = tlb_test_pkg::PAGE_W;
  localparam int WAY_W = tlb_test_pkg::WAY_W;
  localparam int ENTRY_W = tlb_test_pkg::ENTRY_W;
  localparam int LRU_W = tlb_test_pkg::LRU_W;

  // Control word fields
  logic [PAGE_W-1:0] ctl_page;
  logic ctl_valid;
  logic [tlb_test_pkg::ATTR_W-1:0] ctl_attr;
  logic ctl_cmd;

  // Data word fields
  logic [PAGE_W-1:0] dat_page;
  logic [LRU_W-1:0] dat_lru;
  logic dat_hit;
  logic [WAY_W-1:0] dat_way;

  // TLB state held outside the entry store so that it resets
  logic [ENTRIES-1:0] entry_valid;
  logic [LRU_W-1:0] set_lru [SETS];
  tlb_test_pkg::op_state_t state;

  // Access decode
  wire priv_ok = (privilege_level == tlb_test_pkg::PRIV_KERNEL);
  wire idle = (state == tlb_test_pkg::OP_IDLE);
  wire access_ok = priv_ok && idle;
  wire wr_ctl = test_reg_write && access_ok && (test_reg_sel == tlb_test_pkg::REG_SEL_CONTROL);
  wire wr_dat = test_reg_write && access_ok && (test_reg_sel == tlb_test_pkg::REG_SEL_DATA);
  wire rd_any = test_reg_read && access_ok;
  wire denied = (test_reg_write || test_reg_read) && !access_ok;
  wire start_lookup = wr_ctl && (test_reg_wdata[tlb_test_pkg::CMD_BIT] == tlb_test_pkg::CMD_LOOKUP);
  wire start_write = wr_ctl && (test_reg_wdata[tlb_test_pkg::CMD_BIT] != tlb_test_pkg::CMD_LOOKUP);

  wire [IDX_W-1:0] start_set = test_reg_wdata[tlb_test_pkg::LIN_LO +: IDX_W];
  wire [IDX_W-1:0] cur_set = ctl_page[IDX_W-1:0];
  wire [LRU_W-1:0] cur_lru = set_lru[cur_set];

  // Pseudo-LRU victim: leave the most recent half, then its less recent way
  function automatic logic [WAY_W-1:0] plru_victim(input logic [LRU_W-1:0] lru);
    logic [WAY_W-1:0] way;
    way = 2'h0;
    if (lru[tlb_test_pkg::PLRU_HALF]) begin
      way = lru[tlb_test_pkg::PLRU_HIGH_PAIR] ? 2'h3 : 2'h2;
    end else begin
      way = lru[tlb_test_pkg::PLRU_LOW_PAIR] ? 2'h1 : 2'h0;
    end
    return way;
  endfunction : plru_victim

  // Mark a way as most recently used
  function automatic logic [LRU_W-1:0] plru_touch(
    input logic [LRU_W-1:0] lru,
    input logic [WAY_W-1:0] way
  );
    logic [LRU_W-1:0] upd;
    upd = lru;
    upd[tlb_test_pkg::PLRU_HALF] = !way[1];
    if (!way[1]) begin
      upd[tlb_test_pkg::PLRU_LOW_PAIR] = (way == 2'h0);
    end else begin
      upd[tlb_test_pkg::PLRU_HIGH_PAIR] = (way == 2'h2);
    end
    return upd;
  endfunction : plru_touch

  // Entry store and its ports
  logic [tlb_test_pkg::WAYS*ENTRY_W-1:0] rd_ways;
  wire do_write = (state == tlb_test_pkg::OP_WRITE);
  // Set field used only with hit flag
  wire [WAY_W-1:0] write_way = dat_hit ? dat_way : plru_victim(cur_lru);
  // Pair 01 stores 0, 10 stores 1; upper bit is the stored value
  wire [tlb_test_pkg::ATTR_PAIRS-1:0] write_attr = {ctl_attr[5], ctl_attr[3], ctl_attr[1]};
  // Tag of linear page plus attributes; valid bit kept beside it
  // Entry allocated to the control word's linear page
  // Physical page stored into the entry
  wire [ENTRY_W-1:0] write_entry = {ctl_page, write_attr, dat_page};
  wire [IDX_W+WAY_W-1:0] write_index = {cur_set, write_way};

  tlb_entry_store #(
    .SETS(SETS),
    .WAYS(tlb_test_pkg::WAYS),
    .WIDTH(ENTRY_W)
  ) u_store (
    .clk_sys(clk_sys),
    .rd_en(start_lookup),
    .rd_set(start_set),
    .wr_en(do_write),
    .wr_set(cur_set),
    .wr_way(write_way),
    .wr_entry(write_entry),
    .rd_ways(rd_ways)
  );

  // Per-way compare
  logic [tlb_test_pkg::WAYS-1:0] way_hit;
  logic [PAGE_W-1:0] way_phys [tlb_test_pkg::WAYS];
  logic [tlb_test_pkg::ATTR_PAIRS-1:0] way_attr [tlb_test_pkg::WAYS];

  for (genvar w = 0; w < tlb_test_pkg::WAYS; w++) begin : g_way
    wire [ENTRY_W-1:0] ent = rd_ways[w*ENTRY_W +: ENTRY_W];
    wire [PAGE_W-1:0] ent_page = ent[ENTRY_W-1 -: PAGE_W];
    wire [tlb_test_pkg::ATTR_PAIRS-1:0] ent_attr = ent[PAGE_W +: tlb_test_pkg::ATTR_PAIRS];
    wire [IDX_W+WAY_W-1:0] ent_index = {cur_set, WAY_W'(w)};
    logic [tlb_test_pkg::ATTR_PAIRS-1:0] pair_ok;
    for (genvar k = 0; k < tlb_test_pkg::ATTR_PAIRS; k++) begin : g_pair
      // Upper bit accepts a stored one, lower bit a stored zero
      assign pair_ok[k] = (ctl_attr[2*k+1] && ent_attr[k]) || (ctl_attr[2*k] && !ent_attr[k]);
    end
    // Compare against control word's linear page
    assign way_hit[w] = entry_valid[ent_index] && (ent_page == ctl_page) && (&pair_ok);
    assign way_phys[w] = ent[PAGE_W-1:0];
    assign way_attr[w] = ent_attr;
  end

  // Lowest matching way wins
  logic [WAY_W-1:0] hit_way;
  always_comb begin
    hit_way = 2'h0;
    for (int w = tlb_test_pkg::WAYS - 1; w >= 0; w--) begin
      if (way_hit[w]) begin
        hit_way = w[WAY_W-1:0];
      end
    end
  end
  wire lookup_hit = |way_hit;
  wire [tlb_test_pkg::ATTR_PAIRS-1:0] hit_attr = way_attr[hit_way];
  // Pairs rebuilt from the stored attributes
  wire [tlb_test_pkg::ATTR_W-1:0] hit_pairs = {hit_attr[2], !hit_attr[2], hit_attr[1],
                                               !hit_attr[1], hit_attr[0], !hit_attr[0]};

  // Read words with reserved positions as zero
  // Pairs placed at their control word positions
  wire [31:0] ctl_word = {ctl_page, ctl_valid, ctl_attr, {tlb_test_pkg::CTL_GAP_W{1'b0}}, ctl_cmd};
  wire [31:0] dat_word = {dat_page, {tlb_test_pkg::DAT_GAP_HI_W{1'b0}}, dat_lru,
                          {tlb_test_pkg::DAT_GAP_MID_W{1'b0}}, dat_hit, dat_way,
                          {tlb_test_pkg::DAT_GAP_LO_W{1'b0}}};
  wire [31:0] next_rdata = (test_reg_sel == tlb_test_pkg::REG_SEL_DATA) ? dat_word : ctl_word;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= tlb_test_pkg::OP_IDLE;
    end else begin
      unique case (state)
        tlb_test_pkg::OP_IDLE: begin
          if (start_lookup) begin
            state <= tlb_test_pkg::OP_LOOKUP;
          end else if (start_write) begin
            state <= tlb_test_pkg::OP_WRITE;
          end
        end
        tlb_test_pkg::OP_LOOKUP: state <= tlb_test_pkg::OP_IDLE;
        tlb_test_pkg::OP_WRITE: state <= tlb_test_pkg::OP_IDLE;
      endcase
    end
  end

  // Control word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_page <= tlb_test_pkg::WORD_RESET[PAGE_W-1:0];
      ctl_valid <= 1'b0;
      ctl_attr <= tlb_test_pkg::WORD_RESET[tlb_test_pkg::ATTR_W-1:0];
      ctl_cmd <= 1'b0;
    end else if (wr_ctl) begin
      ctl_page <= test_reg_wdata[tlb_test_pkg::LIN_LO +: PAGE_W];
      ctl_valid <= test_reg_wdata[tlb_test_pkg::VALID_BIT];
      ctl_attr <= test_reg_wdata[tlb_test_pkg::ATTR_LO +: tlb_test_pkg::ATTR_W];
      ctl_cmd <= test_reg_wdata[tlb_test_pkg::CMD_BIT];
    end else if ((state == tlb_test_pkg::OP_LOOKUP) && lookup_hit) begin
      // Valid and attributes from the matching entry
      ctl_valid <= 1'b1;
      ctl_attr <= hit_pairs;
    end
  end

  // Data word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dat_page <= tlb_test_pkg::WORD_RESET[PAGE_W-1:0];
      dat_lru <= tlb_test_pkg::LRU_RESET;
      dat_hit <= 1'b0;
      dat_way <= tlb_test_pkg::WORD_RESET[WAY_W-1:0];
    end else if (wr_dat) begin
      dat_page <= test_reg_wdata[tlb_test_pkg::PHYS_LO +: PAGE_W];
      dat_lru <= test_reg_wdata[tlb_test_pkg::LRU_LO +: LRU_W];
      dat_hit <= test_reg_wdata[tlb_test_pkg::HIT_BIT];
      dat_way <= test_reg_wdata[tlb_test_pkg::WAYSEL_LO +: WAY_W];
    end else if (state == tlb_test_pkg::OP_LOOKUP) begin
      // Replacement bits as they stood before this lookup
      dat_lru <= cur_lru;
      dat_hit <= lookup_hit;
      if (lookup_hit) begin
        // Physical page of the matching entry
        dat_page <= way_phys[hit_way];
        // Way in which the tag was found
        dat_way <= hit_way;
      end
    end
  end

  // Valid bits and replacement state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      entry_valid <= '0;
      for (int s = 0; s < SETS; s++) begin
        set_lru[s] <= tlb_test_pkg::LRU_RESET;
      end
    end else if (do_write) begin
      // Valid bit decides valid or invalidated
      entry_valid[write_index] <= ctl_valid;
      set_lru[cur_set] <= plru_touch(cur_lru, write_way);
    end else if ((state == tlb_test_pkg::OP_LOOKUP) && lookup_hit) begin
      set_lru[cur_set] <= plru_touch(cur_lru, hit_way);
    end
  end

  // Read data and refusal pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      test_reg_rdata <= tlb_test_pkg::WORD_RESET;
      access_denied <= 1'b0;
    end else begin
      access_denied <= denied;
      if (rd_any) begin
        test_reg_rdata <= next_rdata;
      end
    end
  end

  assign busy = !idle;

endmodule : tlb_test_access

// ==== tlb_test_access_checker.sv ====
// Port-level assertions for the TLB test access block
`timescale 1ns/1ps
module tlb_test_access_checker #(
  parameter int ENTRIES = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic test_reg_write,
  input wire logic test_reg_read,
  input wire logic test_reg_sel,
  input wire logic [31:0] test_reg_wdata,
  input wire logic [1:0] privilege_level,
  input wire logic [31:0] test_reg_rdata,
  input wire logic access_denied,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire take_ok = privilege_level == tlb_test_pkg::PRIV_KERNEL && !busy;
  wire refused = (test_reg_write || test_reg_read) && !take_ok;
  wire ctl_take = test_reg_write && take_ok && test_reg_sel == tlb_test_pkg::REG_SEL_CONTROL;
  wire rd_take = test_reg_read && take_ok;
  sequence s_lookup_never;
    ctl_take && test_reg_wdata[0] == tlb_test_pkg::CMD_LOOKUP && (test_reg_wdata[10:9] == 2'h0 ||
      test_reg_wdata[8:7] == 2'h0 || test_reg_wdata[6:5] == 2'h0);
  endsequence
  sequence s_read_data;
    rd_take && test_reg_sel == tlb_test_pkg::REG_SEL_DATA;
  endsequence
  a_denied_on_priv: assert property (refused |=> access_denied)
    else $error("refused access without denial pulse");
  a_denied_has_cause: assert property (access_denied |-> $past(refused))
    else $error("denial pulse without refused access");
  a_busy_after_ctl: assert property (ctl_take |=> busy ##1 !busy)
    else $error("control write did not run for one cycle");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(ctl_take))
    else $error("operation started without control write");
  a_rdata_holds: assert property (!rd_take |=> $stable(test_reg_rdata))
    else $error("read data changed without accepted read");
  a_data_gaps_zero: assert property (s_read_data |=> test_reg_rdata[11:10] == 2'h0 &&
    test_reg_rdata[6:5] == 2'h0 && test_reg_rdata[1:0] == 2'h0)
    else $error("data word reserved bits not zero");
  a_ctl_gaps_zero: assert property (rd_take && test_reg_sel == tlb_test_pkg::REG_SEL_CONTROL
    |=> test_reg_rdata[4:1] == 4'h0)
    else $error("control word reserved bits not zero");
  a_pair_never: assert property (s_lookup_never ##1 busy ##1 s_read_data
    |=> !test_reg_rdata[tlb_test_pkg::HIT_BIT])
    else $error("lookup with pair 00 reported a hit");
endmodule : tlb_test_access_checker

bind tlb_test_access tlb_test_access_checker #(.ENTRIES(ENTRIES)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .test_reg_write(test_reg_write),
  .test_reg_read(test_reg_read), .test_reg_sel(test_reg_sel),
  .test_reg_wdata(test_reg_wdata), .privilege_level(privilege_level),
  .test_reg_rdata(test_reg_rdata), .access_denied(access_denied), .busy(busy));

// ==== tlb_test_access_bench.sv ====
// Self-checking bench for the TLB test access block
`timescale 1ns/1ps
module tlb_test_access_bench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic test_reg_write = 1'b0;
  logic test_reg_read = 1'b0;
  logic test_reg_sel = 1'b0;
  logic [31:0] test_reg_wdata = 32'h0;
  logic [1:0] privilege_level = 2'h0;
  logic [31:0] test_reg_rdata;
  logic access_denied;
  logic busy;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] got;
  // Lookup rows: control word, hit, replacement bits, way, page
  logic [31:0] row_ctl [8] = '{32'h12345_7E1, 32'h12345_4C1, 32'h12345_3E1, 32'h12345_1E1,
    32'h12346_7E1, 32'h12346_321, 32'h12347_7E1, 32'h02345_7E1};
  logic row_hit [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [2:0] row_lru [8] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h0, 3'h4};
  logic [1:0] row_way [8] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [19:0] row_page [8] = '{20'hABCDE, 20'hABCDE, 20'h0, 20'h0, 20'h13579, 20'h13579,
    20'h0, 20'h0};

  tlb_test_access #(.ENTRIES(32)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .test_reg_write(test_reg_write),
    .test_reg_read(test_reg_read), .test_reg_sel(test_reg_sel),
    .test_reg_wdata(test_reg_wdata), .privilege_level(privilege_level),
    .test_reg_rdata(test_reg_rdata), .access_denied(access_denied), .busy(busy));

  always #20 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] actual, input logic [31:0] expected);
    cmp_count++;
    if (actual !== expected) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, actual, expected);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic sel, input logic [31:0] data);
    test_reg_write = 1'b1;
    test_reg_sel = sel;
    test_reg_wdata = data;
    @(negedge clk_sys);
    test_reg_write = 1'b0;
    if (privilege_level != tlb_test_pkg::PRIV_KERNEL) begin
      // Refused write pulses the denial output
      check({31'h0, access_denied}, 32'h1);
    end
    if (sel == tlb_test_pkg::REG_SEL_CONTROL && privilege_level == 2'h0) begin
      // Operation runs one cycle
      check({31'h0, busy}, 32'h1);
    end
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic sel, output logic [31:0] data);
    test_reg_read = 1'b1;
    test_reg_sel = sel;
    @(negedge clk_sys);
    test_reg_read = 1'b0;
    @(negedge clk_sys);
    data = test_reg_rdata;
  endtask : rd

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 2000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    rd(tlb_test_pkg::REG_SEL_CONTROL, got);
    check(got, tlb_test_pkg::WORD_RESET);
    rd(tlb_test_pkg::REG_SEL_DATA, got);
    check(got, tlb_test_pkg::WORD_RESET);
    // Entry in set 5 way 2 by explicit way, entry in set 6 by replacement choice
    wr(tlb_test_pkg::REG_SEL_DATA, 32'hABCDE_018);
    wr(tlb_test_pkg::REG_SEL_CONTROL, 32'h12345_CC0);
    wr(tlb_test_pkg::REG_SEL_DATA, 32'h13579_000);
    wr(tlb_test_pkg::REG_SEL_CONTROL, 32'h12346_B20);
    for (int i = 0; i < 8; i++) begin
      wr(tlb_test_pkg::REG_SEL_CONTROL, row_ctl[i]);
      rd(tlb_test_pkg::REG_SEL_DATA, got);
      check({31'h0, got[4]}, {31'h0, row_hit[i]});
      check({29'h0, got[9:7]}, {29'h0, row_lru[i]});
      if (row_hit[i]) begin
        check({12'h0, got[31:12]}, {12'h0, row_page[i]});
        check({30'h0, got[3:2]}, {30'h0, row_way[i]});
      end
    end
    // Hit refreshes valid and attribute fields of the control word
    wr(tlb_test_pkg::REG_SEL_CONTROL, 32'h12345_7E1);
    rd(tlb_test_pkg::REG_SEL_CONTROL, got);
    check({got[31:1], 1'b0}, 32'h12345_CC0);
    // Refused access leaves the control word alone
    privilege_level = 2'h3;
    wr(tlb_test_pkg::REG_SEL_CONTROL, 32'h55555_000);
    privilege_level = 2'h0;
    rd(tlb_test_pkg::REG_SEL_CONTROL, got);
    check({got[31:1], 1'b0}, 32'h12345_CC0);
    // Read during a running operation is refused
    test_reg_write = 1'b1;
    test_reg_sel = tlb_test_pkg::REG_SEL_CONTROL;
    test_reg_wdata = 32'h12347_7E1;
    @(negedge clk_sys);
    test_reg_write = 1'b0;
    test_reg_read = 1'b1;
    @(negedge clk_sys);
    test_reg_read = 1'b0;
    check({31'h0, access_denied}, 32'h1);
    @(negedge clk_sys);
    check({31'h0, access_denied}, 32'h0);
    // Invalidate the set 5 entry, then look it up again
    wr(tlb_test_pkg::REG_SEL_DATA, 32'hABCDE_018);
    wr(tlb_test_pkg::REG_SEL_CONTROL, 32'h12345_4C0);
    wr(tlb_test_pkg::REG_SEL_CONTROL, 32'h12345_7E1);
    rd(tlb_test_pkg::REG_SEL_DATA, got);
    check({31'h0, got[4]}, 32'h0);
    end_of_test();
  end
endmodule : tlb_test_access_bench
